/* logic/mdsc_consts.vh */
// constants for the memory dac serial control block
`ifndef MDSC_CONSTS_VH
`define MDSC_CONSTS_VH

// reference clock
`define MDSC_CLK_NS        10

// data and address layout
`define MDSC_DATA_W        8
`define MDSC_ADDR_W        2
// address as {addr_bit_second, addr_bit_first}
`define MDSC_ADDR_CHAN     2'h2
`define MDSC_START_BIT     1'h1

// value held in non-volatile memory at power-up (arbitrary default)
`define MDSC_NV_INIT       8'h80

// chip select glitch filter, least time rounded up to whole cycles
`define MDSC_CS_FILT_NS    30
`define MDSC_CS_FILT_CYC   ((`MDSC_CS_FILT_NS + `MDSC_CLK_NS - 1) / `MDSC_CLK_NS)

// erase/write cycle, longest time rounded down to whole cycles
`define MDSC_STORE_MS      5
`define MDSC_STORE_CYC     ((`MDSC_STORE_MS * 1000000) / `MDSC_CLK_NS)

// serial clock edges after the last data bit before a new frame
`define MDSC_GAP_EDGES     2

// frame state codes
`define MDSC_ST_IDLE       3'h0
`define MDSC_ST_ADDR       3'h1
`define MDSC_ST_DATA       3'h2
`define MDSC_ST_GAP        3'h3
`define MDSC_ST_BUSY       3'h4

`endif

/* logic/mdsc_serial_ctrl.v */
// serial control logic of a single-channel 8-bit memory dac
//
// Functional notes
// - the 8-bit control register selects one of 256 output steps.
// - address and data bits travel least significant bit first.
// - a frame begins only after a start bit of value one.
// - serial input is sampled on each rising serial clock edge while select is high and no store runs.
// - frame is start bit, two address bits, eight data bits, select high.
// - new value reaches the output in the cycle after the last data bit.
// - loaded value holds only while select is high, reloadable freely.
// - select low restores the stored value and floats the serial output.
// - select low pulses shorter than the filter window are ignored.
// - each rising serial edge drives the next old bit onto the output.
// - output starts after start and address bits, only with select high.
// - every transfer shifts out the old value; only a frame to the channel address overwrites it.
// - a new frame is accepted two serial clocks after the last data bit.
// - without a store request on the first clock after the last data bit the received value is dropped.
// - store request drives ready low until the store completes.
// - during a store serial input is ignored and the output floats.
// - with the supply too low, ready stays high and nothing is stored.
// - at power-up the stored value loads without any serial clock.
// - the only channel has first address bit zero, second bit one.
`timescale 1ns/1ps
`include "mdsc_consts.vh"
`default_nettype none

module mdsc_serial_ctrl #(
  parameter          DW        = `MDSC_DATA_W,
  parameter [DW-1:0] NV_INIT   = `MDSC_NV_INIT,
  parameter integer  STORE_CYC = `MDSC_STORE_CYC,
  parameter integer  CNT_W     = 20
) (
  input  wire          i_ref_clk,
  input  wire          i_rstn,
  input  wire          i_sclk,
  input  wire          i_cs,
  input  wire          i_serial_in,
  input  wire          i_store_request,
  input  wire          i_supply_ok,
  output wire          o_serial_out,
  output wire          o_serial_out_en,
  output wire          o_store_ready,
  output wire [DW-1:0] o_dac_code,
  output wire [DW-1:0] o_nv_value
);

  // ****************************************************************
  // local constants
  // ****************************************************************
  localparam [2:0]       ST_IDLE  = `MDSC_ST_IDLE;
  localparam [2:0]       ST_ADDR  = `MDSC_ST_ADDR;
  localparam [2:0]       ST_DATA  = `MDSC_ST_DATA;
  localparam [2:0]       ST_GAP   = `MDSC_ST_GAP;
  localparam [2:0]       ST_BUSY  = `MDSC_ST_BUSY;
  // integer forms first, then cut on purpose to the counter widths
  localparam integer     FILT_I   = `MDSC_CS_FILT_CYC - 1;
  localparam integer     BIT_I    = DW - 1;
  localparam integer     ADDR_I   = `MDSC_ADDR_W - 1;
  localparam integer     GAP_I    = `MDSC_GAP_EDGES - 1;
  localparam integer     BUSY_I   = STORE_CYC - 1;
  localparam [3:0]       FILT_MAX = FILT_I[3:0];
  localparam [3:0]       BIT_LAST = BIT_I[3:0];
  localparam [3:0]       ADDR_END = ADDR_I[3:0];
  localparam [3:0]       GAP_END  = GAP_I[3:0];
  localparam [1:0]       ADDR_CH  = `MDSC_ADDR_CHAN;
  localparam [CNT_W-1:0] BUSY_END = BUSY_I[CNT_W-1:0];

  // ****************************************************************
  // state
  // ****************************************************************
  reg             sclk_q;
  reg             cs_f_q;
  reg  [3:0]      cs_cnt_q;
  reg             por_q;
  reg  [2:0]      st_q;
  reg  [3:0]      bit_q;
  reg  [1:0]      addr_q;
  reg  [DW-1:0]   rx_q;
  reg  [DW-1:0]   sr_q;
  reg             so_q;
  reg  [DW-1:0]   store_request_q;
  reg             store_request_vld_q;
  reg  [DW-1:0]   nv_q;
  reg  [DW-1:0]   dac_q;
  reg  [CNT_W-1:0] busy_cnt_q;

  wire            sclk_rise;
  wire            cs_drop;
  wire [DW-1:0]   rx_full;
  wire [1:0]      addr_full;

  // the serial clock is treated as a synchronous level; a rising edge is
  // simply a low-to-high change seen between two reference clock samples
  assign sclk_rise = i_sclk & ~sclk_q;
  assign rx_full   = {i_serial_in, rx_q[DW-1:1]};
  assign addr_full = {i_serial_in, addr_q[1]};

  // ****************************************************************
  // chip select filter
  // ****************************************************************
  // select rises at once but only falls after it has stayed low for
  // the whole filter window, so a short spike never wipes the
  // volatile setting; the price is a short delay on a real fall
  assign cs_drop = cs_f_q & ~i_cs & (cs_cnt_q == FILT_MAX);

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_q   <= 1'h0;
      cs_f_q   <= 1'h0;
      cs_cnt_q <= 4'h0;
    end else begin
      sclk_q <= i_sclk;
      if (i_cs) begin
        cs_f_q   <= 1'h1;
        cs_cnt_q <= 4'h0;
      end else if (cs_drop) begin
        cs_f_q   <= 1'h0;
        cs_cnt_q <= 4'h0;
      end else if (cs_f_q) begin
        cs_cnt_q <= cs_cnt_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // frame engine, store cycle and dac register
  // ****************************************************************
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_q      <= 1'h1;
      st_q       <= ST_IDLE;
      bit_q      <= 4'h0;
      addr_q     <= 2'h0;
      rx_q       <= {DW{1'b0}};
      sr_q       <= {DW{1'b0}};
      so_q       <= 1'h0;
      store_request_q     <= {DW{1'b0}};
      store_request_vld_q <= 1'h0;
      nv_q       <= NV_INIT;
      dac_q      <= {DW{1'b0}};
      busy_cnt_q <= {CNT_W{1'b0}};
    end else if (por_q) begin
      // recall from non-volatile memory, no serial clock needed
      por_q <= 1'h0;
      dac_q <= nv_q;
    end else if (st_q == ST_BUSY) begin
      // store runs to completion; input ignored meanwhile
      if (cs_drop) begin
        dac_q <= nv_q;
      end
      if (busy_cnt_q == BUSY_END) begin
        nv_q       <= store_request_q;
        store_request_vld_q <= 1'h0;
        st_q       <= ST_IDLE;
        busy_cnt_q <= {CNT_W{1'b0}};
      end else begin
        busy_cnt_q <= busy_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else if (cs_drop) begin
      // select low: volatile setting lost, partial frame dropped
      dac_q      <= nv_q;
      st_q       <= ST_IDLE;
      bit_q      <= 4'h0;
      store_request_vld_q <= 1'h0;
      so_q       <= 1'h0;
    end else if (sclk_rise && cs_f_q) begin
      case (st_q)
        ST_IDLE: begin
          if (i_serial_in == `MDSC_START_BIT) begin
            st_q  <= ST_ADDR;
            bit_q <= 4'h0;
          end
        end
        ST_ADDR: begin
          addr_q <= addr_full;
          if (bit_q == ADDR_END) begin
            // old contents start leaving on this edge
            st_q  <= ST_DATA;
            bit_q <= 4'h0;
            so_q  <= dac_q[0];
            sr_q  <= {1'b0, dac_q[DW-1:1]};
          end else begin
            bit_q <= bit_q + 4'h1;
          end
        end
        ST_DATA: begin
          rx_q <= rx_full;
          so_q <= sr_q[0];
          sr_q <= {1'b0, sr_q[DW-1:1]};
          if (bit_q == BIT_LAST) begin
            st_q  <= ST_GAP;
            bit_q <= 4'h0;
            if (addr_q == ADDR_CH) begin
              // visible from the next cycle onward
              dac_q      <= rx_full;
              store_request_q     <= rx_full;
              store_request_vld_q <= 1'h1;
            end
          end else begin
            bit_q <= bit_q + 4'h1;
          end
        end
        ST_GAP: begin
          so_q <= 1'h0;
          if (bit_q == 4'h0 && i_store_request && store_request_vld_q && i_supply_ok) begin
            // a store only starts if the supply can program
            st_q       <= ST_BUSY;
            bit_q      <= 4'h0;
            busy_cnt_q <= {CNT_W{1'b0}};
          end else if (bit_q == GAP_END) begin
            st_q       <= ST_IDLE;
            bit_q      <= 4'h0;
            store_request_vld_q <= 1'h0;
          end else begin
            bit_q <= bit_q + 4'h1;
          end
        end
        default: begin
          st_q  <= ST_IDLE;
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_serial_out    = so_q;
  assign o_serial_out_en = cs_f_q & (st_q != ST_BUSY);
  assign o_store_ready   = (st_q != ST_BUSY);
  assign o_dac_code      = dac_q;
  assign o_nv_value      = nv_q;

endmodule

`default_nettype wire

/* verif/mdsc_host.sv */
// host model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module mdsc_host (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  output logic      o_sclk = 1'b0,
  output logic      o_cs   = 1'b0,
  output logic      o_sdi  = 1'b0,
  output logic      o_store_request = 1'b0
);
  // one serial clock: data moves only while the clock is low
  task automatic tick(input logic b, output logic r);
    @(negedge i_ref_clk);
    o_sdi  = b;
    o_sclk = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    o_sclk = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    r = i_so;
  endtask
  task automatic sel(input logic v, input int n);
    @(negedge i_ref_clk);
    o_cs = v;
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic frame(input logic [1:0] a, input logic [7:0] d, input logic p,
                       output logic [7:0] old);
    logic [10:0] bits;
    logic        r;
    bits = {d, a, 1'b1};
    for (int k = 0; k < 13; k++) begin
      tick(k < 11 ? bits[k] : 1'b0, r);
      if (k == 0) o_store_request = p;
      if (k >= 2 && k <= 9) old[k-2] = r;
    end
    o_store_request = 1'b0;
    // released data line must not keep its last level
    o_sdi  = ~o_sdi;
  endtask
endmodule
`default_nettype wire

/* verif/mdsc_monitor.sv */
// port checker for the memory dac serial control block
`timescale 1ns/1ps
`default_nettype none
module mdsc_monitor #(
  parameter int DW        = 8,
  parameter int STORE_CYC = 20
) (
  input wire logic          i_ref_clk,
  input wire logic          i_rstn,
  input wire logic          i_sclk,
  input wire logic          i_cs,
  input wire logic          i_serial_in,
  input wire logic          i_store_request,
  input wire logic          i_supply_ok,
  input wire logic          o_serial_out,
  input wire logic          o_serial_out_en,
  input wire logic          o_store_ready,
  input wire logic [DW-1:0] o_dac_code,
  input wire logic [DW-1:0] o_nv_value
);
  localparam int BUSY_MAX = STORE_CYC + 2;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // ****
  // assertions and cover points
  // ****
  cs_release_a: assert property ((!i_cs) [*3] |=> !o_serial_out_en)
    else $error("serial output still driven");
  cs_restore_a: assert property ((!i_cs) [*3] ##0 o_store_ready |=> o_dac_code == o_nv_value)
    else $error("no restore on select low");
  cs_glitch_a: assert property (i_cs && o_serial_out_en ##1 !i_cs ##1 i_cs && o_store_ready |=> o_serial_out_en)
    else $error("glitch dropped select");
  cs_rise_a: assert property ($rose(i_cs) |=> o_serial_out_en || !o_store_ready)
    else $error("output not active");
  busy_float_a: assert property (!o_store_ready |-> !o_serial_out_en)
    else $error("output driven in store");
  busy_len_a: assert property ($fell(o_store_ready) |-> ##[1:BUSY_MAX] $rose(o_store_ready))
    else $error("store never ends");
  busy_cause_a: assert property ($fell(o_store_ready) |-> $past(i_store_request && i_supply_ok))
    else $error("store without request");
  nv_update_a: assert property ($changed(o_nv_value) |-> $rose(o_store_ready))
    else $error("memory changed outside store");
  dac_hold_a: assert property ($changed(o_dac_code) && o_serial_out_en |-> $past(i_sclk))
    else $error("dac changed without clock");
  so_shift_a: assert property ($changed(o_serial_out) && o_serial_out_en |-> $past(i_sclk))
    else $error("output moved without clock");
  store_c: cover property ($fell(o_store_ready));
  restore_c: cover property ((!i_cs) [*3]);
  glitch_c: cover property (o_serial_out_en ##1 !i_cs ##1 i_cs);
endmodule
`default_nettype wire

/* verif/memory_dac_serial_control_test.sv */
// testbench for the memory dac serial control block
`timescale 1ns/1ps
`default_nettype none
module memory_dac_serial_control_test;
  logic       ref_clk;
  logic       rstn = 1'b0;
  logic       supply_ok = 1'b1;
  logic [7:0] old;
  logic       r;
  wire        sclk, cs, sdi, store_request, so, so_en, rdy;
  wire  [7:0] dac, nv;
  int         miscompares = 0;
  int         samples_checked = 0;
  mdsc_serial_ctrl #(.STORE_CYC(20)) u_dut (.i_ref_clk(ref_clk), .i_rstn(rstn),
    .i_sclk(sclk), .i_cs(cs), .i_serial_in(sdi), .i_store_request(store_request),
    .i_supply_ok(supply_ok), .o_serial_out(so), .o_serial_out_en(so_en),
    .o_store_ready(rdy), .o_dac_code(dac), .o_nv_value(nv));
  mdsc_host u_host (.i_ref_clk(ref_clk), .i_so(so), .o_sclk(sclk), .o_cs(cs),
    .o_sdi(sdi), .o_store_request(store_request));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_write;
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h5A, 1'b0, old);
    chk(old, 8'h80);
    chk(dac, 8'h5A);
    u_host.frame(2'h2, 8'hC3, 1'b0, old);
    chk(old, 8'h5A);
    chk(dac, 8'hC3);
    u_host.sel(1'b0, 5);
    chk(dac, 8'h80);
    chk(so_en, 1'b0);
  endtask
  task automatic t_store;
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h3C, 1'b1, old);
    chk(rdy, 1'b0);
    chk(so_en, 1'b0);
    repeat (5) u_host.tick(1'b0, r);
    chk(rdy, 1'b1);
    chk(nv, 8'h3C);
    u_host.sel(1'b0, 5);
    chk(dac, 8'h3C);
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h00, 1'b0, old);
    chk(old, 8'h3C);
    u_host.sel(1'b0, 5);
    chk(dac, 8'h3C);
  endtask
  task automatic t_low_supply;
    supply_ok = 1'b0;
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h11, 1'b1, old);
    chk(rdy, 1'b1);
    chk(old, 8'h3C);
    chk(nv, 8'h3C);
    supply_ok = 1'b1;
    u_host.frame(2'h1, 8'hFF, 1'b0, old);
    chk(dac, 8'h11);
    chk(old, 8'h11);
    u_host.sel(1'b0, 5);
  endtask
  task automatic t_glitch;
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h77, 1'b0, old);
    u_host.sel(1'b0, 1);
    u_host.sel(1'b1, 3);
    chk(dac, 8'h77);
    chk(so_en, 1'b1);
    repeat (4) u_host.tick(1'b1, r);
    u_host.sel(1'b0, 5);
    chk(dac, 8'h3C);
    u_host.sel(1'b1, 2);
    u_host.frame(2'h2, 8'h66, 1'b0, old);
    chk(dac, 8'h66);
    chk(old, 8'h3C);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(dac, 8'h80);
    chk(rdy, 1'b1);
    t_write;
    t_store;
    t_low_supply;
    t_glitch;
    summarize;
  end
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
endmodule
bind mdsc_serial_ctrl mdsc_monitor #(.DW(DW), .STORE_CYC(STORE_CYC)) u_mon (.*);
`default_nettype wire
